// ### hdl/wdt_pkg.sv
// Constants, register map and carrier types of the watchdog and power-mode controller.
// Notes on behaviour
// [R1] Reset delay is one-shot, fired by three causes.
// [R2] Stop recovery delays only when recovery bit set.
// [R3] Delay clock from RC or crystal; holds execution.
// [R4] Halt stops processor clock, oscillator keeps running.
// [R5] Halt ends on enabled interrupt or reset.
// [R6] Reset-ended halt restarts at fixed address.
// [R7] Stop halts clocks; exits only by restart.
// [R8] Watchdog is retriggerable one-shot resetting device.
// [R9] First watchdog instruction enables, later ones restart.
// [R10] Watchdog instruction updates zero, sign, overflow flags.
// [R11] Mode register writable only sixty clocks after restart.
// [R12] Mode register unreadable, at expanded location 0FH.
// [R13] Mode bit 4 selects RC or crystal clock.
// [R14] Mode bits 0 and 1 pick timeout tap.
// [R15] Mode bits 2, 3 allow counting in halt, stop.
// [R16] Bits 3 and 4 set: stop uses external clock.
// [R17] Mode bits 5 to 7 reserved, no function.
// [R18] Stop timeout delays but keeps configuration registers.
// [R19] Tap periods and delay length are parameters.
package wdt_pkg;

  // Register indices and byte addresses; the mode register index is not word aligned.
  localparam logic [7:0] WDT_MODE_IDX = 8'h0F;
  localparam logic [7:0] ADDR_WDT_MODE = {WDT_MODE_IDX[5:0], 2'b00};
  localparam logic [7:0] ADDR_STATUS = 8'h40;
  localparam logic [7:0] ADDR_CLEAR = 8'h44;
  localparam logic [7:0] ADDR_ENABLE = 8'h48;
  localparam logic [7:0] ADDR_STATE = 8'h4C;
  localparam logic [7:0] ADDR_RECOVERY = 8'h50;

  // Field positions of the mode register and of the stop recovery register.
  localparam int MODE_HALT_RUN = 2;
  localparam int MODE_STOP_RUN = 3;
  localparam int MODE_XTAL_SEL = 4;
  localparam int REC_DELAY = 5;
  localparam logic [7:0] MODE_USED_MASK = 8'h1F;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] RECOVERY_RESET = 8'h00;

  // Event bits of the status, clear and enable registers.
  localparam int EV_TIMEOUT = 0;
  localparam int EV_HALT_WAKE = 1;
  localparam int EV_STOP_WAKE = 2;
  localparam int EV_POWER_OK = 3;
  localparam int EV_LOCKED_WR = 4;
  localparam int EV_W = 5;

  // Write window after each restart, in system clocks.
  localparam logic [6:0] WIN_CLKS = 7'h3C;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Flag values handed to the core by the watchdog instruction (zero, sign, overflow).
  localparam logic [2:0] WDT_FLAGS = 3'h0;

  typedef enum logic [3:0] {
    PM_RUN = 4'b0001,
    PM_HALT = 4'b0010,
    PM_STOP = 4'b0100,
    PM_DELAY = 4'b1000
  } pmode_t;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } axi_rsp_t;

  typedef struct packed {
    logic wdt_instr;
    logic halt_instr;
    logic stop_instr;
    logic irq_request;
  } core_req_t;

  typedef struct packed {
    logic clk_en;
    logic osc_en;
    logic hold;
    logic restart;
    logic dev_reset;
    logic flag_update;
    logic [2:0] flags;
  } core_rsp_t;

endpackage

// ### hdl/wdt_power_ctrl.sv
// Watchdog, reset delay and halt/stop power-mode controller with an AXI4-Lite register slave.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
module wdt_power_ctrl #(
  parameter logic [15:0] TAP0_TICKS = 16'h0400,
  parameter logic [15:0] TAP1_TICKS = 16'h0800,
  parameter logic [15:0] TAP2_TICKS = 16'h1000,
  parameter logic [15:0] TAP3_TICKS = 16'h2000,
  parameter logic [15:0] DELAY_TICKS = 16'h0400,
  parameter logic [7:0] RC_DIV = 8'h19
) (
  // Clock and synchronous reset.
  input wire logic clk,
  input wire logic reset,
  // Register bus.
  input wire wdt_pkg::axi_req_t axi_in,
  output wdt_pkg::axi_rsp_t axi_out,
  // Processor core.
  input wire wdt_pkg::core_req_t core_in,
  output wdt_pkg::core_rsp_t core_out,
  // Wake and clock sources.
  input wire logic power_good,
  input wire logic stop_recovery_in,
  input wire logic crystal_input_pin,
  // Interrupt.
  output logic irq
);
  import wdt_pkg::*;

  typedef struct packed {
    pmode_t mode;
    logic [15:0] dly_cnt;
    logic [15:0] wdt_cnt;
    logic wdt_on;
    logic [7:0] rc_div;
    logic xtal_q;
    logic pg_q;
    logic [6:0] win_cnt;
    logic locked;
    logic [7:0] mode_reg;
    logic [7:0] rec_reg;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] enable;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    axi_rsp_t axi;
    core_rsp_t core;
    logic irq;
  } state_t;

  state_t s_ff;
  state_t nxt_s;
  logic rc_tick;
  logic xtal_edge;
  logic tick;
  logic wdt_active;
  logic timeout;
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] clr;

  // Terminal count of the watchdog for a tap code.
  function automatic logic [15:0] tap_limit(input logic [1:0] tap);
    logic [15:0] lim;
    unique case (tap)
      2'h0: lim = TAP0_TICKS;
      2'h1: lim = TAP1_TICKS;
      2'h2: lim = TAP2_TICKS;
      default: lim = TAP3_TICKS;
    endcase
    return lim;
  endfunction

  // Read data for a register address; the mode register always reads as zero.
  function automatic logic [31:0] read_word(input state_t s, input logic [7:0] addr);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (addr)
      ADDR_STATUS: d[EV_W-1:0] = s.status;
      ADDR_ENABLE: d[EV_W-1:0] = s.enable;
      ADDR_RECOVERY: d[7:0] = s.rec_reg;
      ADDR_STATE: d = {16'h0000, 8'h00, s.locked, s.wdt_on, 2'h0, s.mode};
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  // True when the address is one the slave decodes.
  function automatic logic mapped(input logic [7:0] addr);
    return addr == ADDR_WDT_MODE || addr == ADDR_STATUS || addr == ADDR_CLEAR ||
           addr == ADDR_ENABLE || addr == ADDR_STATE || addr == ADDR_RECOVERY;
  endfunction

  // All next-state logic; priorities run power fail, then timeout, then mode changes.
  always_comb begin
    nxt_s = s_ff;
    events = '0;
    clr = '0;
    nxt_s.core.restart = 1'b0;
    nxt_s.core.dev_reset = 1'b0;
    nxt_s.core.flag_update = 1'b0;
    nxt_s.core.flags = WDT_FLAGS;

    // The RC oscillator is modelled as a divided tick; the crystal pin is edge counted.
    rc_tick = (s_ff.rc_div == RC_DIV - 8'h01);
    nxt_s.rc_div = rc_tick ? 8'h00 : s_ff.rc_div + 8'h01;
    xtal_edge = crystal_input_pin & ~s_ff.xtal_q;
    nxt_s.xtal_q = crystal_input_pin;
    nxt_s.pg_q = power_good;

    // Clock source of delay and watchdog; in stop with bits 3 and 4 set only the pin counts.
    if (s_ff.mode_reg[MODE_XTAL_SEL]) begin // see [R13] see [R3]
      tick = xtal_edge;
    end else begin
      tick = rc_tick;
    end
    if (s_ff.mode == PM_STOP && s_ff.mode_reg[MODE_STOP_RUN] &&
        s_ff.mode_reg[MODE_XTAL_SEL]) begin // see [R16]
      tick = xtal_edge;
    end

    // Watchdog runs in run mode, and in halt or stop only when allowed.
    wdt_active = s_ff.wdt_on && (s_ff.mode == PM_RUN ||
      (s_ff.mode == PM_HALT && s_ff.mode_reg[MODE_HALT_RUN]) ||
      (s_ff.mode == PM_STOP && s_ff.mode_reg[MODE_STOP_RUN])); // see [R15]
    timeout = wdt_active && tick &&
      (s_ff.wdt_cnt == tap_limit(s_ff.mode_reg[1:0]) - 16'h0001); // see [R14] see [R19]

    // Watchdog instruction: enable on the first, restart on every later one.
    if (core_in.wdt_instr && s_ff.mode == PM_RUN) begin
      nxt_s.wdt_on = 1'b1; // see [R9]
      nxt_s.wdt_cnt = 16'h0000; // see [R9]
      nxt_s.core.flag_update = 1'b1; // see [R10]
    end else if (wdt_active && tick) begin
      nxt_s.wdt_cnt = s_ff.wdt_cnt + 16'h0001;
    end

    // Mode sequencing.
    unique case (s_ff.mode)
      PM_RUN: begin
        if (core_in.halt_instr) begin
          nxt_s.mode = PM_HALT;
        end else if (core_in.stop_instr) begin
          nxt_s.mode = PM_STOP;
        end
      end
      PM_HALT: begin
        // Only an enabled interrupt resumes; execution continues past the halt.
        if (core_in.irq_request) begin // see [R5]
          nxt_s.mode = PM_RUN;
          events[EV_HALT_WAKE] = 1'b1;
        end
      end
      PM_STOP: begin
        if (stop_recovery_in) begin
          events[EV_STOP_WAKE] = 1'b1;
          if (s_ff.rec_reg[REC_DELAY]) begin // see [R2] see [R1]
            nxt_s.mode = PM_DELAY;
            nxt_s.dly_cnt = 16'h0000;
          end else begin
            // Bypass suits fast-starting clocks; restart at once.
            nxt_s.mode = PM_RUN; // see [R7]
            nxt_s.core.restart = 1'b1;
            nxt_s.win_cnt = 7'h00;
            nxt_s.locked = 1'b0;
          end
        end
      end
      PM_DELAY: begin
        // One-shot: counts once to its end, then releases the core.
        if (tick) begin // see [R3]
          nxt_s.dly_cnt = s_ff.dly_cnt + 16'h0001;
          if (s_ff.dly_cnt == DELAY_TICKS - 16'h0001) begin // see [R1] see [R19]
            nxt_s.mode = PM_RUN;
            nxt_s.core.restart = 1'b1; // see [R6]
            nxt_s.win_cnt = 7'h00;
            nxt_s.locked = 1'b0;
          end
        end
      end
    endcase

    // Watchdog expiry always passes through the reset delay.
    if (timeout) begin // see [R8] see [R1]
      events[EV_TIMEOUT] = 1'b1;
      nxt_s.mode = PM_DELAY;
      nxt_s.dly_cnt = 16'h0000;
      nxt_s.wdt_on = 1'b0;
      nxt_s.wdt_cnt = 16'h0000;
      if (s_ff.mode != PM_STOP) begin
        // Outside stop the device resets, mode and recovery registers included; enable and status bits are kept.
        nxt_s.core.dev_reset = 1'b1; // see [R8]
        nxt_s.mode_reg = MODE_RESET;
        nxt_s.rec_reg = RECOVERY_RESET;
      end // In stop the configuration is kept. see [R18]
    end

    // Power fail holds the delay at its start; power good fires it.
    if (!power_good) begin
      nxt_s.mode = PM_DELAY;
      nxt_s.dly_cnt = 16'h0000;
      nxt_s.wdt_on = 1'b0;
      nxt_s.wdt_cnt = 16'h0000;
      nxt_s.core.restart = 1'b0;
    end else if (!s_ff.pg_q) begin // see [R1]
      events[EV_POWER_OK] = 1'b1;
    end

    // Write window runs only while instructions execute.
    if (nxt_s.mode == PM_RUN && s_ff.mode == PM_RUN && !s_ff.locked) begin
      nxt_s.win_cnt = s_ff.win_cnt + 7'h01;
      if (s_ff.win_cnt == WIN_CLKS - 7'h01) begin // see [R11]
        nxt_s.locked = 1'b1;
      end
    end

    // Write address and data are taken in either order and held.
    if (axi_in.awvalid && s_ff.axi.awready) begin
      nxt_s.axi.awready = 1'b0;
      nxt_s.aw_addr = axi_in.awaddr;
    end
    if (axi_in.wvalid && s_ff.axi.wready) begin
      nxt_s.axi.wready = 1'b0;
      nxt_s.w_data = axi_in.wdata;
      nxt_s.w_strb = axi_in.wstrb;
    end

    // Perform the write once both halves are held.
    if (!s_ff.axi.awready && !s_ff.axi.wready && !s_ff.axi.bvalid) begin
      nxt_s.axi.bvalid = 1'b1;
      nxt_s.axi.bresp = RESP_OKAY;
      unique case (s_ff.aw_addr)
        ADDR_WDT_MODE: begin
          // A locked register ignores the write and raises the locked-write event, as hardware protection.
          if (s_ff.locked) begin // see [R11]
            events[EV_LOCKED_WR] = 1'b1;
          end else if (s_ff.w_strb[0]) begin
            nxt_s.mode_reg = s_ff.w_data[7:0] & MODE_USED_MASK; // see [R17] see [R12]
          end
        end
        ADDR_CLEAR: begin
          if (s_ff.w_strb[0]) begin
            clr = s_ff.w_data[EV_W-1:0];
          end
        end
        ADDR_ENABLE: begin
          if (s_ff.w_strb[0]) begin
            nxt_s.enable = s_ff.w_data[EV_W-1:0];
          end
        end
        ADDR_RECOVERY: begin
          if (s_ff.w_strb[0]) begin
            nxt_s.rec_reg = s_ff.w_data[7:0];
          end
        end
        default: nxt_s.axi.bresp = RESP_SLVERR;
      endcase
    end
    if (s_ff.axi.bvalid && axi_in.bready) begin
      nxt_s.axi.bvalid = 1'b0;
      nxt_s.axi.awready = 1'b1;
      nxt_s.axi.wready = 1'b1;
    end

    // Read channel: one read at a time, answered the cycle after the address.
    if (axi_in.arvalid && s_ff.axi.arready) begin
      nxt_s.axi.arready = 1'b0;
      nxt_s.axi.rvalid = 1'b1;
      nxt_s.axi.rdata = read_word(s_ff, axi_in.araddr); // see [R12]
      nxt_s.axi.rresp = (mapped(axi_in.araddr) && axi_in.araddr != ADDR_CLEAR) ?
                        RESP_OKAY : RESP_SLVERR;
    end
    if (s_ff.axi.rvalid && axi_in.rready) begin
      nxt_s.axi.rvalid = 1'b0;
      nxt_s.axi.arready = 1'b1;
    end

    // Sticky events: a set in the same cycle as its clear wins.
    nxt_s.status = (s_ff.status & ~clr) | events;
    nxt_s.irq = |(nxt_s.status & nxt_s.enable);

    // Clock gates follow the mode so the outputs stay registered.
    nxt_s.core.clk_en = (nxt_s.mode == PM_RUN); // see [R4] see [R7]
    nxt_s.core.osc_en = (nxt_s.mode != PM_STOP); // see [R4] see [R7]
    nxt_s.core.hold = (nxt_s.mode == PM_DELAY); // see [R3]
  end

  // Single state register; reset starts the power-on delay.
  always_ff @(posedge clk) begin
    if (reset) begin
      s_ff <= '0;
      s_ff.mode <= PM_DELAY;
      s_ff.mode_reg <= MODE_RESET;
      s_ff.rec_reg <= RECOVERY_RESET;
      s_ff.axi.awready <= 1'b1;
      s_ff.axi.wready <= 1'b1;
      s_ff.axi.arready <= 1'b1;
      s_ff.core.osc_en <= 1'b1;
      s_ff.core.hold <= 1'b1;
      s_ff.core.flags <= WDT_FLAGS;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign axi_out = s_ff.axi;
  assign core_out = s_ff.core;
  assign irq = s_ff.irq;

endmodule

// ### bench/wdt_power_ctrl_chk.sv
// Port-level assertions for the watchdog and power-mode controller.
`timescale 1ns/10ps
module wdt_chk (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Watched ports.
  input wire wdt_pkg::axi_req_t axi_in,
  input wire wdt_pkg::axi_rsp_t axi_out,
  input wire wdt_pkg::core_req_t core_in,
  input wire wdt_pkg::core_rsp_t core_out,
  input wire logic power_good,
  input wire logic stop_recovery_in,
  input wire logic crystal_input_pin,
  input wire logic irq
);
  import wdt_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // A held core must never get a clock, or it would run before the delay ends.
  hold_no_clk_a: assert property (core_out.hold |-> !core_out.clk_en)
    else $error("core clock enabled during reset delay");
  stop_no_clk_a: assert property (!core_out.osc_en |-> !core_out.clk_en)
    else $error("core clock running with oscillator off");
  halt_enter_a: assert property (core_in.halt_instr && core_out.clk_en
    |=> !core_out.clk_en && core_out.osc_en)
    else $error("halt did not stop only the core clock");
  halt_stay_a: assert property (core_out.osc_en && !core_out.clk_en && !core_out.hold
    && !core_in.irq_request && !core_out.dev_reset && power_good |=> !core_out.clk_en)
    else $error("halt left without a wake source");
  wdt_flags_a: assert property (core_in.wdt_instr && core_out.clk_en
    |=> core_out.flag_update && core_out.flags == WDT_FLAGS)
    else $error("watchdog instruction gave no flag update");
  timeout_delay_a: assert property (core_out.dev_reset |-> ##[0:1] core_out.hold)
    else $error("watchdog reset without reset delay");
  power_delay_a: assert property (!power_good |-> ##[0:1] core_out.hold)
    else $error("power fail did not hold the core");
  restart_pulse_a: assert property (core_out.restart |=> !core_out.restart)
    else $error("restart pulse longer than one cycle");
  bresp_hold_a: assert property (axi_out.bvalid && !axi_in.bready
    |=> axi_out.bvalid && $stable(axi_out.bresp))
    else $error("write response dropped before taken");
endmodule

bind wdt_power_ctrl wdt_chk chk (.clk(clk), .reset(reset), .axi_in(axi_in),
  .axi_out(axi_out), .core_in(core_in), .core_out(core_out), .power_good(power_good),
  .stop_recovery_in(stop_recovery_in), .crystal_input_pin(crystal_input_pin), .irq(irq));

// ### bench/core_model.sv
// Behavioural processor core issuing watchdog, halt and stop instructions.
`timescale 1ns/10ps
module core_model (
  // Clock.
  input wire logic clk,
  // Controller side.
  input wire wdt_pkg::core_rsp_t rsp,
  output wdt_pkg::core_req_t req,
  // Bench wishes: watchdog, halt, stop, interrupt.
  input wire logic [3:0] want
);
  import wdt_pkg::*;
  initial req = '0;
  // Instructions only issue while the core is clocked, as a stopped core fetches nothing.
  always @(posedge clk) begin
    req.wdt_instr <= want[0] && rsp.clk_en;
    req.halt_instr <= want[1] && rsp.clk_en;
    req.stop_instr <= want[2] && rsp.clk_en;
    req.irq_request <= want[3];
  end
endmodule

// ### bench/tb.sv
// Self-checking bench for the watchdog and power-mode controller.
`timescale 1ns/10ps
module tb;
  import wdt_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  axi_req_t ai = '0;
  axi_rsp_t ao;
  core_req_t ci;
  core_rsp_t co;
  logic power_good = 1'b1;
  logic rec = 1'b0;
  logic xtal = 1'b0;
  logic irq;
  logic [3:0] want = 4'h0;
  integer fails = 0;
  integer cmp_count = 0;
  integer seed = 32'h2165;
  integer n = 0;
  integer k;
  integer holds = 0;
  integer resets = 0;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [31:0] v;

  // Tap two is never selected here, so it keeps its default period.
  wdt_power_ctrl #(.TAP0_TICKS(16'h0004), .TAP1_TICKS(16'h0008),
    .TAP3_TICKS(16'h0010), .DELAY_TICKS(16'h0004), .RC_DIV(8'h02)) dut (.clk(clk),
    .reset(reset), .axi_in(ai), .axi_out(ao), .core_in(ci), .core_out(co),
    .power_good(power_good), .stop_recovery_in(rec), .crystal_input_pin(xtal), .irq(irq));
  core_model core (.clk(clk), .rsp(co), .req(ci), .want(want));

  initial forever #20 clk = ~clk;

  // Crystal ticks arrive at random so its input is never idle.
  always @(posedge clk) xtal <= 1'($random(seed));

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Every wait but the fixed reset and lock-window delays goes through here, so a hang ends in the report.
  task automatic tick();
    @(posedge clk);
    n++;
    if (n > 400) begin
      fails++;
      final_report();
    end
  endtask

  // Bus answers are matched against the oldest note; hold and reset cycles are counted.
  always @(posedge clk) begin
    if (ao.rvalid && ai.rready) check({ao.rresp, ao.rdata}, rq.pop_front());
    if (ao.bvalid && ai.bready) check({32'h0, ao.bresp}, {32'h0, bq.pop_front()});
    if (co.hold) holds++;
    if (co.dev_reset) resets++;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    ai.awaddr <= a;
    ai.wdata <= d;
    ai.wstrb <= 4'hF;
    ai.awvalid <= 1'b1;
    ai.wvalid <= 1'b1;
    ai.bready <= 1'b1;
    n = 0;
    do begin
      tick();
      if (ao.awready) ai.awvalid <= 1'b0;
      if (ao.wready) ai.wvalid <= 1'b0;
    end while (ai.awvalid || ai.wvalid);
    while (!ao.bvalid) tick();
    ai.bready <= 1'b0;
    tick();
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    ai.araddr <= a;
    ai.arvalid <= 1'b1;
    ai.rready <= 1'b1;
    n = 0;
    do tick(); while (!ao.arready);
    ai.arvalid <= 1'b0;
    while (!ao.rvalid) tick();
    ai.rready <= 1'b0;
    tick();
  endtask

  // One instruction pulse through the core model.
  task automatic ins(input logic [3:0] w);
    want <= w;
    tick();
    want <= 4'h0;
    tick();
  endtask

  task automatic run_wait();
    n = 0;
    while (co.clk_en !== 1'b1) tick();
  endtask

  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    run_wait();
    // Test 1: one early mode write, then lock; odd places answer with errors.
    wr(ADDR_CLEAR, 32'h1F, RESP_OKAY);
    wr(ADDR_WDT_MODE, 32'hE1, RESP_OKAY);
    rd(ADDR_WDT_MODE, {RESP_OKAY, 32'h0});
    rd(8'h80, {RESP_SLVERR, 32'h0});
    wr(ADDR_STATUS, 32'h1, RESP_SLVERR);
    rd(ADDR_CLEAR, {RESP_SLVERR, 32'h0});
    repeat (60) @(posedge clk);
    wr(ADDR_WDT_MODE, 32'h03, RESP_OKAY);
    rd(ADDR_STATUS, {RESP_OKAY, 32'h10});
    rd(ADDR_STATE, {RESP_OKAY, 32'h81});
    wr(ADDR_CLEAR, 32'h1F, RESP_OKAY);
    $display("Test 1 done");
    // Test 2: refreshes keep the watchdog quiet; silence times out on tap one.
    wr(ADDR_ENABLE, 32'h01, RESP_OKAY);
    ins(4'h1);
    tick();
    check({30'h0, co.flag_update, co.flags}, 34'h8);
    repeat (4) begin
      repeat (10) tick();
      ins(4'h1);
    end
    check(34'(resets), 34'h0);
    n = 0;
    while (co.dev_reset !== 1'b1) tick();
    k = n;
    check({33'h0, k >= 13 && k <= 19}, 34'h1);
    run_wait();
    check({33'h0, irq}, 34'h1);
    rd(ADDR_STATUS, {RESP_OKAY, 32'h01});
    wr(ADDR_CLEAR, 32'h01, RESP_OKAY);
    check({33'h0, irq}, 34'h0);
    $display("Test 2 done");
    // Test 3: halt keeps the oscillator and ends on an interrupt.
    ins(4'h2);
    repeat (5) tick();
    check({32'h0, co.clk_en, co.osc_en}, 34'h1);
    ins(4'h8);
    run_wait();
    rd(ADDR_STATUS, {RESP_OKAY, 32'h02});
    $display("Test 3 done");
    // Test 4: stop recovery bypasses the delay unless the recovery bit asks for it.
    ins(4'h4);
    tick();
    check({32'h0, co.clk_en, co.osc_en}, 34'h0);
    k = holds;
    rec <= 1'b1;
    tick();
    rec <= 1'b0;
    run_wait();
    check(34'(holds - k), 34'h0);
    wr(ADDR_RECOVERY, 32'h20, RESP_OKAY);
    rd(ADDR_RECOVERY, {RESP_OKAY, 32'h20});
    ins(4'h4);
    rec <= 1'b1;
    tick();
    rec <= 1'b0;
    run_wait();
    check({33'h0, holds > k}, 34'h1);
    $display("Test 4 done");
    // Test 5: a power fail holds the core; recovery flags the rise.
    wr(ADDR_CLEAR, 32'h1F, RESP_OKAY);
    power_good <= 1'b0;
    repeat (3) tick();
    check({33'h0, co.hold}, 34'h1);
    power_good <= 1'b1;
    run_wait();
    rd(ADDR_STATUS, {RESP_OKAY, 32'h08});
    v = $random(seed);
    wr(ADDR_ENABLE, v, RESP_OKAY);
    rd(ADDR_ENABLE, {RESP_OKAY, v & 32'h1F});
    $display("Test 5 done");
    final_report();
  end
endmodule
